// *** pkg/lrod_pkg.sv ***
// Constants for the LED reset path and output drive stage.
// Assumes a single core clock; every other input is sampled on it.
// Contract
// - Power-on release clears registers and bus state.
// - Acknowledge reset call address byte 06h only.
// - Reset call address with read bit unacknowledged.
// - First reset data byte acknowledged only if A5h.
// - Second reset data byte acknowledged only if 5Ah.
// - Bytes after the two data bytes unacknowledged.
// - STOP after full sequence resets to power-up.
// - Any deviating sequence leaves registers untouched.
// - Invert applies only while enable pin low.
// - Static codes map invert and drive to pins.
// - Code 10 totem-pole follows individual PWM.
// - Open-drain keeps upper transistor always off.
// - Invert bit inverts applied PWM waveform.
// - Code 11 combines individual and group PWM.
// - Enable pin high forces disabled output state.
// - Codes mean off, on, PWM, PWM with group.
package lrod_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int LROD_NUM_CH = 8;
	localparam int LROD_CODE_W = 2;
	localparam int LROD_DATA_W = 8;
	localparam int LROD_ADDR_W = 3;

	// ---------------------------------------------------------------
	// Bus reset call
	// ---------------------------------------------------------------
	localparam logic [7:0] LROD_CALL_ADDR_WR = 8'h06;
	localparam logic [7:0] LROD_CALL_ADDR_RD = 8'h07;
	localparam logic [7:0] LROD_CALL_BYTE1 = 8'ha5;
	localparam logic [7:0] LROD_CALL_BYTE2 = 8'h5a;
	localparam logic [3:0] LROD_BIT_LAST = 4'h8;
	localparam logic [3:0] LROD_BIT_ZERO = 4'h0;
	localparam logic [3:0] LROD_BIT_ONE = 4'h1;

	// ---------------------------------------------------------------
	// Register map and fields
	// ---------------------------------------------------------------
	localparam logic [LROD_ADDR_W-1:0] LROD_REG_MODE = 3'h0;
	localparam logic [LROD_ADDR_W-1:0] LROD_REG_CODES_LO = 3'h1;
	localparam logic [LROD_ADDR_W-1:0] LROD_REG_CODES_HI = 3'h2;
	localparam logic [LROD_ADDR_W-1:0] LROD_REG_STATUS = 3'h3;
	localparam int LROD_MODE_INV_BIT = 4;
	localparam int LROD_MODE_DRV_BIT = 2;
	localparam int LROD_MODE_DIS_LSB = 0;
	localparam int LROD_ST_OE_BIT = 0;
	localparam int LROD_ST_BUSY_BIT = 1;
	localparam int LROD_ST_ARMED_BIT = 2;
	localparam logic [LROD_DATA_W-1:0] LROD_DATA_ZERO = 8'h00;
	localparam logic [15:0] LROD_CODES_RST = 16'h0000;
	localparam logic [1:0] LROD_DIS_RST = 2'h0;

	// ---------------------------------------------------------------
	// Output codes and disabled states
	// ---------------------------------------------------------------
	localparam logic [1:0] LROD_CODE_OFF = 2'h0;
	localparam logic [1:0] LROD_CODE_ON = 2'h1;
	localparam logic [1:0] LROD_CODE_IND = 2'h2;
	localparam logic [1:0] LROD_CODE_GRP = 2'h3;
	localparam logic [1:0] LROD_DIS_LOW = 2'h0;
	localparam logic [1:0] LROD_DIS_HIGH = 2'h1;
	localparam logic [1:0] LROD_DIS_HIZ = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_BYTE1,
		ST_BYTE2,
		ST_ARMED,
		ST_IGNORE
	} lrod_state_type;

endpackage

// *** rtl/lrod_drive_stage.sv ***
// One output channel: code, invert, drive type and enable pin to
// transistor controls. Assumes all inputs are on clk_in.
`timescale 1ns/1ps

module lrod_drive_stage
	import lrod_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [LROD_CODE_W-1:0] code_in,
	input wire logic invert_in,
	input wire logic drive_in,
	input wire logic oe_n_in,
	input wire logic [1:0] disabled_in,
	input wire logic ind_pwm_in,
	input wire logic grp_pwm_in,
	output logic upper_out,
	output logic lower_out
);
	logic level;
	logic sink;
	logic upper_d;
	logic lower_d;

	// ---------------------------------------------------------------
	// Transistor decode
	// ---------------------------------------------------------------
	always_comb
	begin
		unique case (code_in)
			LROD_CODE_OFF: level = 1'b0;
			LROD_CODE_ON: level = 1'b1;
			LROD_CODE_IND: level = ind_pwm_in;
			LROD_CODE_GRP: level = ind_pwm_in & grp_pwm_in;
		endcase
		sink = level ^ invert_in;
		if (oe_n_in)
		begin
			// Reserved field releases the pin, the safest choice
			upper_d = (disabled_in == LROD_DIS_HIGH) & drive_in;
			lower_d = (disabled_in == LROD_DIS_LOW);
		end
		else
		begin
			upper_d = ~sink & drive_in;
			lower_d = sink;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			upper_out <= 1'b0;
			lower_out <= 1'b0;
		end
		else
		begin
			upper_out <= upper_d;
			lower_out <= lower_d;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_open_drain: assert property (@(posedge clk_in) disable iff (rst_in)
		!drive_in |=> !upper_out)
		else $error("upper transistor on in open-drain");
	a_no_shoot: assert property (@(posedge clk_in) disable iff (rst_in)
		!(upper_out && lower_out))
		else $error("both transistors on");

endmodule // lrod_drive_stage

// *** rtl/lrod_top.sv ***
// Reset path and eight-channel output drive of an LED driver.
// Assumes a two-wire bus much slower than CORE_CLK_IN, PWM inputs
// from logic on the core clock and a plain local register port.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps

module lrod_top
	import lrod_pkg::*;
(
	input wire logic CORE_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_OUT,
	input wire logic OE_N_IN,
	input wire logic [LROD_NUM_CH-1:0] IND_PWM_IN,
	input wire logic GROUP_PWM_IN,
	input wire logic [LROD_ADDR_W-1:0] REG_ADDR_IN,
	input wire logic [LROD_DATA_W-1:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [LROD_DATA_W-1:0] REG_RDATA_OUT,
	output logic [LROD_NUM_CH-1:0] UPPER_ON_OUT,
	output logic [LROD_NUM_CH-1:0] LOWER_ON_OUT,
	output logic SW_RESET_OUT
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic scl_m_q;
	logic scl_s_q;
	logic scl_d_q;
	logic sda_m_q;
	logic sda_s_q;
	logic sda_d_q;
	logic oe_m_q;
	logic oe_n_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic counting;
	logic byte_end;
	logic ack_ok;
	logic rst_all;
	lrod_state_type state_q;
	logic [3:0] bit_cnt_q;
	logic ack_phase_q;
	logic [7:0] shift_q;
	logic ack_q;
	logic bus_reset_call_q;
	logic output_polarity_invert_q;
	logic output_drive_type_q;
	logic [1:0] disabled_output_state_q;
	logic [LROD_NUM_CH*LROD_CODE_W-1:0] channel_state_codes_q;
	logic [LROD_DATA_W-1:0] status;
	logic [LROD_DATA_W-1:0] rdata_d;
	logic [LROD_DATA_W-1:0] rdata_q;

	// ---------------------------------------------------------------
	// Internal reset
	// ---------------------------------------------------------------
	// The completed call pulses the same reset as power-on
	assign rst_all = SYS_RST_IN | bus_reset_call_q;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_d_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_d_q <= 1'b1;
			// Enable pin held as disabled until sampled twice
			oe_m_q <= 1'b1;
			oe_n_q <= 1'b1;
		end
		else
		begin
			scl_m_q <= SCL_IN;
			scl_s_q <= scl_m_q;
			scl_d_q <= scl_s_q;
			sda_m_q <= SDA_IN;
			sda_s_q <= sda_m_q;
			sda_d_q <= sda_s_q;
			oe_m_q <= OE_N_IN;
			oe_n_q <= oe_m_q;
		end
	end

	assign scl_rise = scl_s_q & ~scl_d_q;
	assign scl_fall = ~scl_s_q & scl_d_q;
	assign start_det = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
	assign stop_det = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;

	// ---------------------------------------------------------------
	// Byte framing
	// ---------------------------------------------------------------
	assign counting = (state_q == ST_ADDR) || (state_q == ST_BYTE1) ||
		(state_q == ST_BYTE2) || (state_q == ST_ARMED);
	assign byte_end = counting & scl_fall & ~ack_phase_q &
		(bit_cnt_q == LROD_BIT_LAST);

	always_ff @(posedge CORE_CLK_IN)
	begin
		if (rst_all || start_det || stop_det)
		begin
			bit_cnt_q <= LROD_BIT_ZERO;
			ack_phase_q <= 1'b0;
			shift_q <= LROD_DATA_ZERO;
		end
		else if (counting && scl_rise && bit_cnt_q != LROD_BIT_LAST)
		begin
			shift_q <= {shift_q[6:0], sda_s_q};
			bit_cnt_q <= bit_cnt_q + LROD_BIT_ONE;
		end
		else if (byte_end)
		begin
			ack_phase_q <= 1'b1;
		end
		else if (scl_fall && ack_phase_q)
		begin
			ack_phase_q <= 1'b0;
			bit_cnt_q <= LROD_BIT_ZERO;
		end
	end

	// ---------------------------------------------------------------
	// Reset call sequence
	// ---------------------------------------------------------------
	// A read address byte differs in its last bit and fails here
	assign ack_ok =
		(state_q == ST_ADDR && shift_q == LROD_CALL_ADDR_WR) ||
		(state_q == ST_BYTE1 && shift_q == LROD_CALL_BYTE1) ||
		(state_q == ST_BYTE2 && shift_q == LROD_CALL_BYTE2);

	always_ff @(posedge CORE_CLK_IN)
	begin
		if (rst_all)
		begin
			state_q <= ST_IDLE;
		end
		else if (start_det)
		begin
			state_q <= ST_ADDR;
		end
		else if (stop_det)
		begin
			state_q <= ST_IDLE;
		end
		else if (byte_end)
		begin
			if (!ack_ok)
			begin
				state_q <= ST_IGNORE;
			end
			else
			begin
				unique case (state_q)
					ST_ADDR: state_q <= ST_BYTE1;
					ST_BYTE1: state_q <= ST_BYTE2;
					ST_BYTE2: state_q <= ST_ARMED;
					ST_ARMED: state_q <= ST_IGNORE;
					ST_IDLE: state_q <= ST_IDLE;
					ST_IGNORE: state_q <= ST_IGNORE;
				endcase
			end
		end
	end

	// Acknowledge drives the data line low for one bus clock
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (rst_all || start_det || stop_det)
		begin
			ack_q <= 1'b0;
		end
		else if (byte_end)
		begin
			ack_q <= ack_ok;
		end
		else if (scl_fall && ack_phase_q)
		begin
			ack_q <= 1'b0;
		end
	end

	// Only a STOP after the second acknowledged data byte fires
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			bus_reset_call_q <= 1'b0;
		end
		else
		begin
			bus_reset_call_q <= stop_det & (state_q == ST_ARMED) & ~bus_reset_call_q;
		end
	end

	assign SDA_OUT = 1'b0;
	assign SDA_OE_OUT = ack_q;
	assign SW_RESET_OUT = bus_reset_call_q;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (rst_all)
		begin
			output_polarity_invert_q <= 1'b0;
			output_drive_type_q <= 1'b0;
			disabled_output_state_q <= LROD_DIS_RST;
		end
		else if (REG_WR_IN && REG_ADDR_IN == LROD_REG_MODE)
		begin
			output_polarity_invert_q <= REG_WDATA_IN[LROD_MODE_INV_BIT];
			output_drive_type_q <= REG_WDATA_IN[LROD_MODE_DRV_BIT];
			disabled_output_state_q <=
				REG_WDATA_IN[LROD_MODE_DIS_LSB +: 2];
		end
	end

	always_ff @(posedge CORE_CLK_IN)
	begin
		if (rst_all)
		begin
			channel_state_codes_q <= LROD_CODES_RST;
		end
		else if (REG_WR_IN && REG_ADDR_IN == LROD_REG_CODES_LO)
		begin
			channel_state_codes_q[7:0] <= REG_WDATA_IN;
		end
		else if (REG_WR_IN && REG_ADDR_IN == LROD_REG_CODES_HI)
		begin
			channel_state_codes_q[15:8] <= REG_WDATA_IN;
		end
	end

	always_comb
	begin
		status = LROD_DATA_ZERO;
		status[LROD_ST_OE_BIT] = oe_n_q;
		status[LROD_ST_BUSY_BIT] = (state_q != ST_IDLE);
		status[LROD_ST_ARMED_BIT] = (state_q == ST_ARMED);
		rdata_d = LROD_DATA_ZERO;
		if (REG_RD_IN)
		begin
			if (REG_ADDR_IN == LROD_REG_MODE)
			begin
				rdata_d[LROD_MODE_INV_BIT] = output_polarity_invert_q;
				rdata_d[LROD_MODE_DRV_BIT] = output_drive_type_q;
				rdata_d[LROD_MODE_DIS_LSB +: 2] = disabled_output_state_q;
			end
			else if (REG_ADDR_IN == LROD_REG_CODES_LO)
			begin
				rdata_d = channel_state_codes_q[7:0];
			end
			else if (REG_ADDR_IN == LROD_REG_CODES_HI)
			begin
				rdata_d = channel_state_codes_q[15:8];
			end
			else if (REG_ADDR_IN == LROD_REG_STATUS)
			begin
				rdata_d = status;
			end
		end
	end

	// Read data stands for the one cycle after the strobe
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (SYS_RST_IN)
		begin
			rdata_q <= LROD_DATA_ZERO;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end
	assign REG_RDATA_OUT = rdata_q;

	// ---------------------------------------------------------------
	// Output drive stages
	// ---------------------------------------------------------------
	for (genvar ch = 0; ch < LROD_NUM_CH; ch++)
	begin : g_stage
		lrod_drive_stage u_stage (
			.clk_in(CORE_CLK_IN),
			.rst_in(rst_all),
			.code_in(channel_state_codes_q[ch*LROD_CODE_W +: LROD_CODE_W]),
			.invert_in(output_polarity_invert_q),
			.drive_in(output_drive_type_q),
			.oe_n_in(oe_n_q),
			.disabled_in(disabled_output_state_q),
			.ind_pwm_in(IND_PWM_IN[ch]),
			.grp_pwm_in(GROUP_PWM_IN),
			.upper_out(UPPER_ON_OUT[ch]),
			.lower_out(LOWER_ON_OUT[ch])
		);
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_por_clear: assert property (@(posedge CORE_CLK_IN)
		SYS_RST_IN |=> state_q == ST_IDLE &&
		channel_state_codes_q == LROD_CODES_RST && !output_drive_type_q)
		else $error("power-on did not clear state");
	a_addr_ack: assert property (@(posedge CORE_CLK_IN)
		disable iff (rst_all)
		byte_end && state_q == ST_ADDR && shift_q == LROD_CALL_ADDR_WR
		|=> ack_q && state_q == ST_BYTE1)
		else $error("write call address not acknowledged");
	a_read_nak: assert property (@(posedge CORE_CLK_IN)
		disable iff (rst_all)
		byte_end && state_q == ST_ADDR && shift_q == LROD_CALL_ADDR_RD
		|=> !ack_q && state_q == ST_IGNORE)
		else $error("read call address acknowledged");
	a_byte1_check: assert property (@(posedge CORE_CLK_IN)
		disable iff (rst_all)
		byte_end && state_q == ST_BYTE1
		|=> ack_q == ($past(shift_q) == LROD_CALL_BYTE1))
		else $error("first data byte answer wrong");
	a_byte2_check: assert property (@(posedge CORE_CLK_IN)
		disable iff (rst_all)
		byte_end && state_q == ST_BYTE2
		|=> ack_q == ($past(shift_q) == LROD_CALL_BYTE2))
		else $error("second data byte answer wrong");
	a_extra_nak: assert property (@(posedge CORE_CLK_IN)
		disable iff (rst_all)
		byte_end && state_q == ST_ARMED |=> !ack_q [*1] ##1 !bus_reset_call_q)
		else $error("extra byte acknowledged");
	a_call_reset: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		stop_det && state_q == ST_ARMED |=> bus_reset_call_q ##1
		(state_q == ST_IDLE && channel_state_codes_q == LROD_CODES_RST))
		else $error("completed call did not reset");
	a_no_reset: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		stop_det && state_q != ST_ARMED |=> !bus_reset_call_q)
		else $error("reset after malformed call");
	a_disabled_low: assert property (@(posedge CORE_CLK_IN)
		disable iff (rst_all)
		oe_n_q && disabled_output_state_q == LROD_DIS_LOW
		&& !REG_WR_IN ##1 !rst_all
		|-> LOWER_ON_OUT == {LROD_NUM_CH{1'b1}} && UPPER_ON_OUT == '0)
		else $error("disabled outputs not low");
	a_enable_static: assert property (@(posedge CORE_CLK_IN)
		disable iff (rst_all)
		!oe_n_q && channel_state_codes_q[1:0] == LROD_CODE_ON
		&& !output_polarity_invert_q ##1 !rst_all |-> LOWER_ON_OUT[0])
		else $error("on code does not sink");
	c_call_done: cover property (@(posedge CORE_CLK_IN) bus_reset_call_q);
	c_read_nak: cover property (@(posedge CORE_CLK_IN)
		byte_end && state_q == ST_ADDR && !ack_ok);
	c_extra_byte: cover property (@(posedge CORE_CLK_IN)
		byte_end && state_q == ST_ARMED);
	c_pwm_out: cover property (@(posedge CORE_CLK_IN)
		!oe_n_q && channel_state_codes_q[1:0] == LROD_CODE_GRP);

endmodule // lrod_top

// *** test/lrod_i2c_master.sv ***
// Two-wire bus master model that sends reset call frames.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps

module lrod_i2c_master
(
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	// Quarter of the 800 ns link period in 100 ns core cycles
	localparam int QTR = 2;

	// Idle bus: both lines released, link clock stands still
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// One clock pulse; data set mid-low, line sampled mid-high
	task automatic put_bit(input logic b, output logic seen);
		scl_out <= 1'b0;
		tick(QTR);
		sda_out <= b;
		tick(QTR);
		scl_out <= 1'b1;
		tick(QTR);
		#1;
		seen = sda_in;
		tick(QTR);
	endtask

	// ---------------------------------------------------------------
	// Frame: START, bytes MSB first, STOP
	// ---------------------------------------------------------------
	task automatic frame(input logic [31:0] bytes, input int n,
		output int acks);
		logic seen;
		acks = 0;
		sda_out <= 1'b0;
		tick(2 * QTR);
		for (int i = 0; i < n; i++)
		begin
			for (int k = 7; k >= 0; k--)
				put_bit(bytes[8 * (3 - i) + k], seen);
			put_bit(1'b1, seen);
			// A missing acknowledge ends the attempt at once
			if (seen !== 1'b0)
				break;
			acks++;
		end
		scl_out <= 1'b0;
		tick(QTR);
		sda_out <= 1'b0;
		tick(QTR);
		scl_out <= 1'b1;
		tick(QTR);
		sda_out <= 1'b1;
		tick(2 * QTR);
	endtask

endmodule // lrod_i2c_master

// *** test/lrod_top_tb_top.sv ***
// Self-checking bench for the reset path and output drive stage.
// Assumes the bus master model in lrod_i2c_master.
`timescale 1ns/1ps

module lrod_top_tb_top
	import lrod_pkg::*;
;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic scl;
	logic sda_m;
	logic sda_o;
	logic sda_oe;
	logic oe_n = 1'b1;
	logic [7:0] ind = 8'h00;
	logic grp = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic [7:0] upper;
	logic [7:0] lower;
	logic swr;
	logic sda_line;
	logic [7:0] d;
	logic [23:0] ex;
	int num_errors = 0;
	int total_checks = 0;
	int pulses = 0;
	int seed = 32'h07cb;
	int acks, p0, pd, n, rv;
	logic [31:0] fr [6] = '{32'h07000000, 32'h0, 32'h06a40000,
		32'h06a55b00, 32'h06a55a00, 32'h06a55a00};
	int fn [6] = '{1, 1, 2, 3, 4, 3};
	int fa [6] = '{0, 0, 1, 2, 3, 3};
	int fe [6] = '{0, 0, 0, 0, 0, 1};

	// Pull-up on the data line; the device only pulls low
	assign sda_line = sda_m & (~sda_oe | sda_o);

	always #50 clk = ~clk;

	always @(posedge clk)
		if (swr === 1'b1)
			pulses <= pulses + 1;

	lrod_top dut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .SCL_IN(scl),
		.SDA_IN(sda_line), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe),
		.OE_N_IN(oe_n), .IND_PWM_IN(ind), .GROUP_PWM_IN(grp),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
		.REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .UPPER_ON_OUT(upper),
		.LOWER_ON_OUT(lower), .SW_RESET_OUT(swr));

	lrod_i2c_master u_master (.clk_in(clk), .sda_in(sda_line),
		.scl_out(scl), .sda_out(sda_m));

	// ---------------------------------------------------------------
	// Checks and bus tasks
	// ---------------------------------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		if (num_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Each call starts on a fresh edge, so a strobe never toggles twice
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	// Expected {upper, lower} worked out from mode, codes and pins
	function automatic logic [15:0] exp_drive(input logic [7:0] m,
		input logic [15:0] cd, input logic oe, input logic [7:0] pw,
		input logic g);
		logic [7:0] up;
		logic [7:0] lo;
		logic lvl;
		logic snk;
		for (int c = 0; c < 8; c++)
		begin
			case (cd[2 * c +: 2])
				2'h0: lvl = 1'b0;
				2'h1: lvl = 1'b1;
				2'h2: lvl = pw[c];
				default: lvl = pw[c] & g;
			endcase
			snk = lvl ^ m[4];
			lo[c] = oe ? (m[1:0] == 2'h0) : snk;
			up[c] = oe ? (m[1:0] == 2'h1) & m[2] : ~snk & m[2];
		end
		return {up, lo};
	endfunction

	task automatic apply(input logic [7:0] m, input logic [15:0] cd,
		input logic oe);
		reg_wr(LROD_REG_MODE, m);
		reg_wr(LROD_REG_CODES_LO, cd[7:0]);
		reg_wr(LROD_REG_CODES_HI, cd[15:8]);
		rv = $random(seed);
		oe_n <= oe;
		ind <= rv[7:0];
		grp <= rv[8];
		repeat (5) @(posedge clk);
		#1;
		chk16({upper, lower}, exp_drive(m, cd, oe_n, ind, grp));
		reg_rd(LROD_REG_CODES_LO, d);
		chk8(d, cd[7:0]);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk16({upper, lower}, 16'h00ff);
		for (int a = 0; a < 8; a++)
		begin
			reg_rd(a[2:0], d);
			chk8(d, (a == 3) ? 8'h01 : 8'h00);
		end
		// Unmapped and read-only places keep their values
		reg_wr(3'h5, 8'hff);
		reg_wr(LROD_REG_STATUS, 8'hfe);
		reg_rd(3'h5, d);
		chk8(d, 8'h00);
		reg_rd(LROD_REG_STATUS, d);
		chk8(d, 8'h01);
		for (int i = 0; i < 64; i++)
		begin
			rv = $random(seed);
			if (i < 32)
				apply({3'h0, i[2], 1'b0, i[1], i[4:3]}, 16'he4e4, i[0]);
			else
				apply(rv[7:0] & 8'h17, rv[23:8], rv[24]);
		end
		apply(8'h14, 16'h1b1b, 1'b0);
		apply(8'h04, 16'h5555, 1'b0);
		rv = $random(seed);
		fr[1][31:24] = (rv[7:0] == 8'h06) ? 8'h08 : rv[7:0];
		for (int f = 0; f < 6; f++)
		begin
			apply(8'h15, 16'h279c, 1'b0);
			p0 = pulses;
			u_master.frame(fr[f], fn[f], acks);
			chk8(acks[7:0], fa[f][7:0]);
			for (n = 0; n < 60 && pulses == p0; n++)
				@(posedge clk);
			if (fe[f] == 1 && n == 60)
			begin
				num_errors++;
				end_of_test();
			end
			repeat (4) @(posedge clk);
			#1;
			pd = pulses - p0;
			if (fe[f] != 2)
			begin
				ex = (fe[f] == 1) ? 24'h0 : 24'h159c27;
				chk8(pd[7:0], fe[f][7:0]);
				chk16({upper, lower}, exp_drive(ex[23:16],
					{ex[7:0], ex[15:8]}, oe_n, ind, grp));
				reg_rd(LROD_REG_MODE, d);
				chk8(d, ex[23:16]);
				reg_rd(LROD_REG_CODES_LO, d);
				chk8(d, ex[15:8]);
				reg_rd(LROD_REG_CODES_HI, d);
				chk8(d, ex[7:0]);
			end
		end
		// Power-on reset again in mid-run, over non-zero registers
		apply(8'h15, 16'h279c, 1'b0);
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk16({upper, lower}, 16'h00ff);
		reg_rd(LROD_REG_MODE, d);
		chk8(d, 8'h00);
		reg_rd(LROD_REG_CODES_HI, d);
		chk8(d, 8'h00);
		end_of_test();
	end

endmodule // lrod_top_tb_top
